// file: verilog/wfc_counter.sv
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - restart event colliding with a channel match corrupts that channel's next period.
// - restart events unsupported in dual-slope ramp modes while dithering.
// - down-counting unsupported in dual-slope ramp modes; direction must stay up.
// - no DMA request on compare match; use overflow or match events.
// - ramp restart fails with prescaler nonzero and clock-edge or sync_resynchronised sync.
// - one-shot DMA blocks overflow DMA trigger in ramp C and CS variants.
module wfc_counter #(
   parameter int NCH = 4,
   parameter int CW  = 16
) (
   // clock and reset
   input  wire logic            ref_clk_i,
   input  wire logic            sys_rst_i,
   // register port
   input  wire logic [7:0]      reg_addr_i,
   input  wire logic [31:0]     reg_wdata_i,
   input  wire logic            reg_wr_i,
   input  wire logic            reg_rd_i,
   output logic [31:0]          reg_rdata_o,
   // event system
   input  wire logic            restart_ev_i,
   output logic [NCH-1:0]       match_ev_o,
   output logic                 ovf_ev_o,
   // dma controller
   output logic                 ovf_dma_req_o,
   output logic [NCH-1:0]       match_dma_req_o,
   // waveform pins
   output logic [NCH-1:0]       wave_o
);
   initial begin
      if (NCH < 1 || NCH > 8 || CW < 2 || CW > 16) begin
         $error("wfc_counter: unsupported parameters");
      end
   end

   wfc_pkg::wfc_ctrl_s          ctrl, next_ctrl;
   logic                        dir, next_dir;
   logic [2:0]                  ev_act, next_ev_act;
   logic [CW-1:0]               period, next_period;
   logic [CW-1:0]               cc [NCH], next_cc [NCH];
   logic [CW-1:0]               count, next_count;
   logic [7:0]                  pcnt, next_pcnt;
   logic                        pend, next_pend;
   logic [NCH-1:0]              corrupt, next_corrupt;
   logic [wfc_pkg::FLT_W-1:0]   fault, next_fault;
   logic                        oneshot_armed, next_oneshot_armed;
   logic [31:0]                 next_rdata;
   logic [NCH-1:0]              next_match, next_wave;
   logic                        next_ovf, next_ovf_dma;

   function automatic logic is_ramp(input wfc_pkg::wfc_wave_e w);
      return w == wfc_pkg::WFC_WAVE_DSCR || w == wfc_pkg::WFC_WAVE_DSCR_A ||
             w == wfc_pkg::WFC_WAVE_DSCR_C || w == wfc_pkg::WFC_WAVE_DSCR_CS;
   endfunction

   logic                        ramp, tick, ovf, restart_req, restart_ok, do_restart;
   logic                        oneshot_dead;
   logic [NCH-1:0]              match;

   always_comb begin
      ramp  = is_ramp(ctrl.wave);
      // divided clock ticks once every 2^div_sel peripheral clocks
      tick  = ctrl.enable && (pcnt == ((8'h01 << ctrl.div_sel) - 8'h01));
      // the overflow trigger is dead in one-shot mode for the c and cs ramps
      oneshot_dead = ctrl.one_shot && (ctrl.wave == wfc_pkg::WFC_WAVE_DSCR_C ||
                     ctrl.wave == wfc_pkg::WFC_WAVE_DSCR_CS);
      ovf   = tick && (count == period);
      for (int i = 0; i < NCH; i++) begin
         match[i] = tick && (count == cc[i]);
      end
      restart_req = ctrl.enable && restart_ev_i && (ev_act == wfc_pkg::EV_ACT_RESTART);
      // restart in the ramp modes is dropped under dithering or a bad sync choice with a nonzero prescaler
      restart_ok  = !(ramp && ctrl.dither) &&
                    !(ramp && ctrl.div_sel != 3'h0 &&
                      ctrl.sync != wfc_pkg::WFC_SYNC_DIV_EDGE);
      // restarts synced to the divided clock wait for its next tick
      do_restart  = (ctrl.sync == wfc_pkg::WFC_SYNC_DIV_EDGE) ?
                    (pend || restart_req) && tick : restart_req;
      do_restart  = do_restart && restart_ok;
   end

   always_comb begin
      next_ctrl        = ctrl;
      next_dir         = dir;
      next_ev_act      = ev_act;
      next_period      = period;
      next_cc          = cc;
      next_fault       = fault;
      next_oneshot_armed = oneshot_armed;
      next_rdata       = 32'h0000_0000;
      next_pcnt        = tick ? 8'h00 : (ctrl.enable ? pcnt + 8'h01 : 8'h00);
      next_pend        = (ctrl.sync == wfc_pkg::WFC_SYNC_DIV_EDGE) &&
                         (pend || restart_req) && !tick;
      next_count       = count;
      if (tick) begin
         // down-count is only honoured outside the ramp modes
         if (dir && !ramp) begin
            next_count = (count == '0) ? period : count - CW'(1);
         end else begin
            next_count = ovf ? '0 : count + CW'(1);
         end
      end
      if (do_restart) begin
         next_count = '0;
         next_pcnt  = 8'h00;
         next_pend  = 1'b0;
      end
      next_corrupt = corrupt;
      for (int i = 0; i < NCH; i++) begin
         // collision spoils the following period of that channel
         if (restart_req && match[i]) next_corrupt[i] = 1'b1;
         else if (ovf) next_corrupt[i] = 1'b0;
         next_wave[i]  = corrupt[i] ? !(count < cc[i]) : (count < cc[i]);
         next_match[i] = match[i];
      end
      next_ovf = ovf;
      // one-shot mode arms a single overflow request per control write
      next_ovf_dma = ovf && !oneshot_dead &&
                     (!ctrl.one_shot || oneshot_armed);
      if (ovf && ctrl.one_shot) next_oneshot_armed = 1'b0;
      // hardware-set fault flags; set beats clear unless the flag is already set, then clear wins
      if (restart_req && |match) next_fault[wfc_pkg::FLT_COLLIDE] = 1'b1;
      if (restart_req && ramp && ctrl.dither) next_fault[wfc_pkg::FLT_DITHER] = 1'b1;
      if (ramp && ctrl.div_sel != 3'h0 && ctrl.sync != wfc_pkg::WFC_SYNC_DIV_EDGE &&
          restart_req)
         next_fault[wfc_pkg::FLT_SYNC] = 1'b1;
      if (ramp && dir) next_fault[wfc_pkg::FLT_DIR] = 1'b1;
      // every overflow in the dead ramps is flagged, even once the one-shot request is spent
      if (ovf && oneshot_dead) next_fault[wfc_pkg::FLT_ONESHOT] = 1'b1;
      if (reg_wr_i) begin
         if (reg_addr_i == wfc_pkg::REG_CTRLA) begin
            next_ctrl.enable = reg_wdata_i[wfc_pkg::CTRLA_ENABLE_BIT];
            next_ctrl.wave   = wfc_pkg::wfc_wave_e'(reg_wdata_i[wfc_pkg::CTRLA_WAVE_LSB +: 3]);
            next_ctrl.div_sel  = reg_wdata_i[wfc_pkg::CTRLA_DIV_LSB +: 3];
            next_ctrl.sync     = wfc_pkg::wfc_sync_e'(reg_wdata_i[wfc_pkg::CTRLA_SYNC_LSB +: 2]);
            next_ctrl.one_shot = reg_wdata_i[wfc_pkg::CTRLA_ONESHOT_BIT];
            next_ctrl.dither   = reg_wdata_i[wfc_pkg::CTRLA_DITHER_BIT];
            next_oneshot_armed = 1'b1;
         end else if (reg_addr_i == wfc_pkg::REG_CTRLB_SET) begin
            if (reg_wdata_i[wfc_pkg::CTRLB_DIR_BIT]) next_dir = 1'b1;
         end else if (reg_addr_i == wfc_pkg::REG_CTRLB_CLR) begin
            if (reg_wdata_i[wfc_pkg::CTRLB_DIR_BIT]) next_dir = 1'b0;
         end else if (reg_addr_i == wfc_pkg::REG_EVCTRL) begin
            next_ev_act = reg_wdata_i[wfc_pkg::EVCTRL_ACT_LSB +: 3];
         end else if (reg_addr_i == wfc_pkg::REG_PERIOD) begin
            next_period = reg_wdata_i[CW-1:0];
         end else if (reg_addr_i == wfc_pkg::REG_FAULT_CLR) begin
            next_fault = next_fault & ~(fault & reg_wdata_i[wfc_pkg::FLT_W-1:0] &
                         ~(next_fault ^ fault));
         end else begin
            for (int i = 0; i < NCH; i++) begin
               if (reg_addr_i == wfc_pkg::REG_CC_BASE + 8'(4 * i)) begin
                  next_cc[i] = reg_wdata_i[CW-1:0];
               end
            end
         end
      end
      if (reg_rd_i) begin
         if (reg_addr_i == wfc_pkg::REG_CTRLA) begin
            next_rdata[wfc_pkg::CTRLA_ENABLE_BIT]      = ctrl.enable;
            next_rdata[wfc_pkg::CTRLA_WAVE_LSB +: 3]   = ctrl.wave;
            next_rdata[wfc_pkg::CTRLA_DIV_LSB +: 3]    = ctrl.div_sel;
            next_rdata[wfc_pkg::CTRLA_SYNC_LSB +: 2]   = ctrl.sync;
            next_rdata[wfc_pkg::CTRLA_ONESHOT_BIT]     = ctrl.one_shot;
            next_rdata[wfc_pkg::CTRLA_DITHER_BIT]      = ctrl.dither;
         end else if (reg_addr_i == wfc_pkg::REG_CTRLB_SET ||
                      reg_addr_i == wfc_pkg::REG_CTRLB_CLR) begin
            next_rdata[wfc_pkg::CTRLB_DIR_BIT] = dir;
         end else if (reg_addr_i == wfc_pkg::REG_EVCTRL) begin
            next_rdata[2:0] = ev_act;
         end else if (reg_addr_i == wfc_pkg::REG_PERIOD) begin
            next_rdata[CW-1:0] = period;
         end else if (reg_addr_i == wfc_pkg::REG_STATUS) begin
            next_rdata[NCH-1:0] = corrupt;
         end else if (reg_addr_i == wfc_pkg::REG_COUNT) begin
            next_rdata[CW-1:0] = count;
         end else if (reg_addr_i == wfc_pkg::REG_FAULT) begin
            next_rdata[wfc_pkg::FLT_W-1:0] = fault;
         end else begin
            for (int i = 0; i < NCH; i++) begin
               if (reg_addr_i == wfc_pkg::REG_CC_BASE + 8'(4 * i)) begin
                  next_rdata[CW-1:0] = cc[i];
               end
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl            <= '0;
         dir             <= 1'b0;
         ev_act          <= 3'h0;
         period          <= wfc_pkg::PERIOD_RESET[CW-1:0];
         for (int i = 0; i < NCH; i++) cc[i] <= '0;
         count           <= '0;
         pcnt            <= 8'h00;
         pend            <= 1'b0;
         corrupt         <= '0;
         fault           <= '0;
         oneshot_armed   <= 1'b0;
         reg_rdata_o     <= 32'h0000_0000;
         match_ev_o      <= '0;
         ovf_ev_o        <= 1'b0;
         ovf_dma_req_o   <= 1'b0;
         match_dma_req_o <= '0;
         wave_o          <= '0;
      end else begin
         ctrl            <= next_ctrl;
         dir             <= next_dir;
         ev_act          <= next_ev_act;
         period          <= next_period;
         cc              <= next_cc;
         count           <= next_count;
         pcnt            <= next_pcnt;
         pend            <= next_pend;
         corrupt         <= next_corrupt;
         fault           <= next_fault;
         oneshot_armed   <= next_oneshot_armed;
         reg_rdata_o     <= next_rdata;
         match_ev_o      <= next_match;
         ovf_ev_o        <= next_ovf;
         ovf_dma_req_o   <= next_ovf_dma;
         match_dma_req_o <= '0;  // compare-match dma trigger is absent
         wave_o          <= next_wave;
      end
   end

   chk_collide_marks: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (restart_req && match[0]) |=> corrupt[0]) else $error("collision not marked");
   chk_dither_block: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (ramp && ctrl.dither) |-> !do_restart) else $error("restart under dither");
   chk_ramp_upcount: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (ramp && tick && !ovf && !do_restart) |=> count == $past(count) + CW'(1))
      else $error("ramp not counting up");
   chk_no_match_dma: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      match_dma_req_o == '0) else $error("match dma raised");
   chk_sync_block: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (ramp && ctrl.div_sel != 3'h0 && ctrl.sync != wfc_pkg::WFC_SYNC_DIV_EDGE) |-> !do_restart)
      else $error("bad sync restart");
   chk_oneshot_block: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      oneshot_dead |=> !ovf_dma_req_o)
      else $error("one-shot dma in ramp c or cs");
   chk_ovf_dma: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (ovf && !ctrl.one_shot) |=> ovf_dma_req_o && ovf_ev_o) else $error("ovf dma lost");
   chk_match_event: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      match[0] |=> match_ev_o[0]) else $error("match event lost");
   chk_pend_wait: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (ctrl.sync == wfc_pkg::WFC_SYNC_DIV_EDGE && restart_req && !tick) |=> pend)
      else $error("divided-clock restart not held");
   chk_restart_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      do_restart |=> count == '0)
      else $error("restart did not clear count");
   chk_corrupt_clear: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (ovf && !restart_req) |=> corrupt == '0)
      else $error("corrupt mark outlived period");
   // a flag must survive until software clears it, or an early check misses it
   chk_fault_sticky: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (fault[wfc_pkg::FLT_COLLIDE] && !(reg_wr_i && reg_addr_i == wfc_pkg::REG_FAULT_CLR))
      |=> fault[wfc_pkg::FLT_COLLIDE])
      else $error("collision flag lost");
   chk_dir_fault: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (ramp && dir) |=> fault[wfc_pkg::FLT_DIR])
      else $error("down-count in ramp not flagged");
   chk_dither_fault: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (restart_req && ramp && ctrl.dither) |=> fault[wfc_pkg::FLT_DITHER])
      else $error("dither restart not flagged");
   chk_oneshot_fault: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (ovf && oneshot_dead) |=> fault[wfc_pkg::FLT_ONESHOT])
      else $error("lost one-shot trigger not flagged");
   chk_oneshot_once: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (ctrl.one_shot && !oneshot_armed && !(reg_wr_i && reg_addr_i == wfc_pkg::REG_CTRLA))
      |=> !ovf_dma_req_o)
      else $error("second one-shot request");
   chk_wave_follow: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !corrupt[0] |=> wave_o[0] == ($past(count) < $past(cc[0])))
      else $error("waveform does not follow compare");
endmodule
`default_nettype wire

// file: verilog/wfc_pkg.sv
package wfc_pkg;
   // register offsets (byte addresses, one word each)
   localparam logic [7:0] REG_CTRLA      = 8'h00;
   localparam logic [7:0] REG_CTRLB_SET  = 8'h04;
   localparam logic [7:0] REG_CTRLB_CLR  = 8'h08;
   localparam logic [7:0] REG_EVCTRL     = 8'h0C;
   localparam logic [7:0] REG_PERIOD     = 8'h10;
   localparam logic [7:0] REG_STATUS     = 8'h14;
   localparam logic [7:0] REG_COUNT      = 8'h18;
   localparam logic [7:0] REG_CC_BASE    = 8'h20;
   localparam logic [7:0] REG_FAULT      = 8'h40;
   localparam logic [7:0] REG_FAULT_CLR  = 8'h44;

   // control A field positions
   localparam int CTRLA_ENABLE_BIT  = 0;
   localparam int CTRLA_WAVE_LSB    = 1;  // 3 bits
   localparam int CTRLA_DIV_LSB     = 4;  // 3 bits
   localparam int CTRLA_SYNC_LSB    = 7;  // 2 bits
   localparam int CTRLA_ONESHOT_BIT = 9;
   localparam int CTRLA_DITHER_BIT  = 10;
   localparam int CTRLB_DIR_BIT     = 0;
   localparam int EVCTRL_ACT_LSB    = 0;  // 3 bits

   localparam logic [2:0] EV_ACT_RESTART = 3'h1;

   typedef enum logic [2:0] {
      WFC_WAVE_NORMAL = 3'h0,
      WFC_WAVE_DSCR   = 3'h4,
      WFC_WAVE_DSCR_A = 3'h5,
      WFC_WAVE_DSCR_C = 3'h6,
      WFC_WAVE_DSCR_CS= 3'h7
   } wfc_wave_e;

   typedef enum logic [1:0] {
      WFC_SYNC_CLK_EDGE  = 2'h0,
      WFC_SYNC_DIV_EDGE  = 2'h1,
      WFC_SYNC_RESAMPLED = 2'h2
   } wfc_sync_e;

   // fault flag bit positions
   localparam int FLT_COLLIDE  = 0;
   localparam int FLT_DITHER   = 1;
   localparam int FLT_DIR      = 2;
   localparam int FLT_SYNC     = 3;
   localparam int FLT_ONESHOT  = 4;
   localparam int FLT_W        = 5;

   typedef struct packed {
      logic       enable;
      wfc_wave_e  wave;
      logic [2:0] div_sel;
      wfc_sync_e  sync;
      logic       one_shot;
      logic       dither;
   } wfc_ctrl_s;

   localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
endpackage

// file: sim/wfc_evsys_model.sv
`timescale 1ns/100ps
`default_nettype none
module wfc_evsys_model (
   // clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   // bench control
   input  wire logic        fire_i,
   input  wire logic        clr_i,
   // block side
   input  wire logic [3:0]  match_ev_i,
   input  wire logic        ovf_ev_i,
   input  wire logic        ovf_dma_req_i,
   input  wire logic [3:0]  match_dma_req_i,
   input  wire logic [3:0]  wave_i,
   output logic             restart_ev_o,
   output logic             redundant_wave_o,
   output logic [15:0]      dma_cnt_o,
   output logic [15:0]      ovf_cnt_o,
   output logic [15:0]      mev_cnt_o,
   output logic [15:0]      mdma_cnt_o
);
   assign restart_ev_o     = fire_i;
   // two channels with successive values cover a corrupted period
   assign redundant_wave_o = wave_i[0] | wave_i[1];
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dma_cnt_o  <= 16'h0000;
         ovf_cnt_o  <= 16'h0000;
         mev_cnt_o  <= 16'h0000;
         mdma_cnt_o <= 16'h0000;
      end else if (clr_i) begin
         dma_cnt_o  <= 16'h0000;
         ovf_cnt_o  <= 16'h0000;
         mev_cnt_o  <= 16'h0000;
         mdma_cnt_o <= 16'h0000;
      end else begin
         dma_cnt_o  <= dma_cnt_o + 16'(ovf_dma_req_i);
         ovf_cnt_o  <= ovf_cnt_o + 16'(ovf_ev_i);
         // match event routed as dma trigger instead of the dead request
         mev_cnt_o  <= mev_cnt_o + 16'(match_ev_i[0]);
         mdma_cnt_o <= mdma_cnt_o + 16'(match_dma_req_i[0]);
      end
   end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        ref_clk, sys_rst, wr, rd, fire, clr, restart_ev, ovf_ev, ovf_dma, rwave;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata;
   logic [3:0]  match_ev, match_dma, wave;
   logic [15:0] dma_cnt, ovf_cnt, mev_cnt, mdma_cnt;
   int          fail_count, checks_done;
   int          hi, rhi;
   wfc_counter #(.NCH(4), .CW(16)) dut (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .restart_ev_i(restart_ev), .match_ev_o(match_ev),
      .ovf_ev_o(ovf_ev), .ovf_dma_req_o(ovf_dma), .match_dma_req_o(match_dma), .wave_o(wave));
   wfc_evsys_model model (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .fire_i(fire),
      .clr_i(clr), .match_ev_i(match_ev), .ovf_ev_i(ovf_ev), .ovf_dma_req_i(ovf_dma),
      .match_dma_req_i(match_dma), .wave_i(wave), .restart_ev_o(restart_ev),
      .redundant_wave_o(rwave), .dma_cnt_o(dma_cnt), .ovf_cnt_o(ovf_cnt),
      .mev_cnt_o(mev_cnt), .mdma_cnt_o(mdma_cnt));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] ctl(input logic [2:0] w, input logic [2:0] p,
                                       input logic [1:0] s, input logic os, input logic dt);
      return 32'h0000_0001 | (32'(w) << wfc_pkg::CTRLA_WAVE_LSB)
           | (32'(p) << wfc_pkg::CTRLA_DIV_LSB) | (32'(s) << wfc_pkg::CTRLA_SYNC_LSB)
           | (32'(os) << wfc_pkg::CTRLA_ONESHOT_BIT) | (32'(dt) << wfc_pkg::CTRLA_DITHER_BIT);
   endfunction
   task automatic run(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr    <= 1'b0;
   endtask
   task automatic cmp32(input string what, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic check_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                            input string what);
      @(posedge ref_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd   <= 1'b0;
      #1 cmp32(what, e, rdata & m);
   endtask
   task automatic restart(input int n);
      @(posedge ref_clk);
      fire <= 1'b1;
      run(n);
      fire <= 1'b0;
   endtask
   // counters cleared at one edge, then a fixed window of edges is counted
   task automatic window(input int n);
      @(posedge ref_clk);
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      run(n);
      #1;
   endtask
   task automatic report_and_stop;
      $display("checks_done %0d fail_count %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      report_and_stop;
   end
   initial begin
      sys_rst = 1'b1; addr = 8'h00; wdata = 32'h0000_0000; wr = 1'b0; rd = 1'b0;
      fire = 1'b0; clr = 1'b0; fail_count = 0; checks_done = 0;
      run(3);
      sys_rst <= 1'b0;
      check_reg(wfc_pkg::REG_PERIOD, 32'hFFFF_FFFF, 32'h0000_FFFF, "period reset");
      check_reg(8'h3C, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
      wr_reg(wfc_pkg::REG_PERIOD, 32'h0000_0003);
      wr_reg(wfc_pkg::REG_CC_BASE, 32'h0000_0001);
      wr_reg(wfc_pkg::REG_CTRLA, ctl(3'h0, 3'h0, 2'h0, 1'b0, 1'b0));
      run(8);
      window(40);
      cmp32("ovf dma", 32'd10, 32'(dma_cnt));
      cmp32("ovf event", 32'd10, 32'(ovf_cnt));
      cmp32("match event", 32'd10, 32'(mev_cnt));
      cmp32("match dma", 32'd0, 32'(mdma_cnt));
      // channel 0 high for one count of four, channel 1 never
      hi = 0;
      rhi = 0;
      repeat (8) begin
         @(posedge ref_clk);
         #1 hi += int'(wave[0]);
         rhi += int'(rwave);
      end
      cmp32("wave duty", 32'd2, 32'(hi));
      cmp32("redundant wave", 32'd2, 32'(rhi));
      // restart held while count sits on the compare value of channel 0
      wr_reg(wfc_pkg::REG_EVCTRL, {29'd0, wfc_pkg::EV_ACT_RESTART});
      wr_reg(wfc_pkg::REG_CC_BASE, 32'h0000_0000);
      restart(4);
      check_reg(wfc_pkg::REG_FAULT, 32'h0000_0001, 32'h0000_0001, "collision");
      check_reg(wfc_pkg::REG_STATUS, 32'h0000_0001, 32'h0000_0001, "corrupt");
      wr_reg(wfc_pkg::REG_FAULT_CLR, 32'h0000_001F);
      check_reg(wfc_pkg::REG_FAULT, 32'h0000_001F, 32'h0000_0000, "fault clear");
      wr_reg(wfc_pkg::REG_CC_BASE, 32'h0000_0001);
      for (int w = 4; w < 8; w++) begin
         wr_reg(wfc_pkg::REG_CTRLA, ctl(3'(w), 3'h0, 2'h0, 1'b0, 1'b1));
         wr_reg(wfc_pkg::REG_CTRLB_SET, 32'h0000_0001);
         restart(1);
         run(2);
         check_reg(wfc_pkg::REG_FAULT, 32'h0000_0006, 32'h0000_0006, "ramp faults");
         wr_reg(wfc_pkg::REG_CTRLB_CLR, 32'h0000_0001);
         wr_reg(wfc_pkg::REG_FAULT_CLR, 32'h0000_001F);
      end
      for (int s = 0; s < 3; s++) begin
         wr_reg(wfc_pkg::REG_CTRLA, ctl(3'h4, 3'h1, 2'(s), 1'b0, 1'b0));
         wr_reg(wfc_pkg::REG_FAULT_CLR, 32'h0000_001F);
         restart(1);
         run(4);
         check_reg(wfc_pkg::REG_FAULT, 32'h0000_0008, (s == 1) ? 32'h0 : 32'h8, "sync");
      end
      for (int w = 6; w < 8; w++) begin
         wr_reg(wfc_pkg::REG_CTRLA, ctl(3'(w), 3'h0, 2'h0, 1'b1, 1'b0));
         window(40);
         cmp32("one-shot ramp dma", 32'd0, 32'(dma_cnt));
         cmp32("ramp ovf seen", 32'd1, {31'd0, ovf_cnt !== 16'h0000});
      end
      window(0);
      wr_reg(wfc_pkg::REG_CTRLA, ctl(3'h0, 3'h0, 2'h0, 1'b1, 1'b0));
      run(40);
      #1 cmp32("one-shot dma", 32'd1, 32'(dma_cnt));
      report_and_stop;
   end
endmodule
`default_nettype wire
